// ===== hw/pwr_seq_pkg.sv
// constants, states and carriers of the power-mode sequencer
package pwr_seq_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int IDLE_WAKE_NS = 14000;
  localparam int STBY_WAKE_NS = 151000;
  localparam int SHDN_WAKE_NS = 1015000;
  localparam int IDLE_WAKE_CYC = IDLE_WAKE_NS / CLK_PERIOD_NS;
  localparam int STBY_WAKE_CYC = STBY_WAKE_NS / CLK_PERIOD_NS;
  localparam int SHDN_WAKE_CYC = SHDN_WAKE_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 17;
  localparam int BOD_PERIOD_CYC = 1024;
  localparam int BOD_ON_CYC = 16;
  // ----------------------------------------
  // clocks
  // ----------------------------------------
  localparam int FAST_XTAL_KHZ = 24000;
  localparam int FAST_CLK_MUL = 2;
  localparam int SYS_CLK_KHZ = FAST_XTAL_KHZ * FAST_CLK_MUL;
  localparam int SLOW_RC_HZ = 32768;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_CAUSE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_WAKE_PIN = 8'h14;
  localparam logic [7:0] ADDR_PAD_OUT = 8'h18;
  localparam logic [7:0] ADDR_PAD_OE = 8'h1C;
  localparam logic [7:0] ADDR_PAD_IN = 8'h20;
  localparam int CTRL_LF_XTAL_BIT = 0;
  localparam int CTRL_LF_PAD_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int IRQ_W = 3;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_TMO_BIT = 1;
  localparam int IRQ_PAD_BIT = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [2:0] CAUSE_POR = 3'h1;
  localparam logic [2:0] CAUSE_PIN = 3'h2;
  localparam logic [2:0] CAUSE_WAKEPIN = 3'h4;
  // ----------------------------------------
  // modes and states
  // ----------------------------------------
  localparam logic [2:0] MODE_IDLE = 3'h1;
  localparam logic [2:0] MODE_STBY = 3'h2;
  localparam logic [2:0] MODE_SHDN = 3'h3;
  localparam logic [2:0] MODE_HELD = 3'h4;
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_IDLE = 3'b001,
    ST_STBY = 3'b010,
    ST_SHDN = 3'b011,
    ST_HELD = 3'b100,
    ST_WAKE = 3'b101
  } pwr_state_e;
  typedef struct packed {
    logic cpu_en;
    logic mem_en;
    logic periph_en;
    logic fast_osc_en;
    logic fast_dbl_en;
  } clk_ctrl_s;
  typedef struct packed {
    logic aon_en;
    logic sensor_en;
    logic bod_en;
    logic por_en;
  } pwr_ctrl_s;
endpackage : pwr_seq_pkg

// ===== hw/power_mode_sequencer.sv
// power-mode sequencer: mode states, clock gating, pad latch, wake and reset cause
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
// Function
// - idle gates cpu and memory clocks, peripherals run, any interrupt wakes
// - wake to active within 14 us idle, 151 us standby, 1015 us shutdown
// - standby keeps only always-on and sensor domains; wakes on external, rtc, sensor events
// - standby wake resumes where it stopped, settings kept
// - all pads stay latched throughout standby
// - shutdown powers everything off except the power-on detector; pads keep pre-entry values
// - edge on a shutdown wake pin wakes and acts as reset
// - reset cause readable: wake pin, reset pin, power-on
// - shutdown keeps only pad latch, power-on detector and nonvolatile memory
// - reset pin wakes from every mode, held included
// - brown-out detector on in active/idle, duty cycled standby, off shutdown
// - power-on detector on in active, idle, standby, shutdown
// - system clock is fast crystal doubled to 48 MHz
// - slow rc oscillator serves as low-speed reference without crystal
// - selected low-speed clock may be routed out on a pad
module power_mode_sequencer #(
  parameter int NPAD = 8,
  parameter int STBY_WAKE_CYC = pwr_seq_pkg::STBY_WAKE_CYC,
  parameter int SHDN_WAKE_CYC = pwr_seq_pkg::SHDN_WAKE_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [31:0] rd_data_out,
  // wake sources
  input wire logic irq_in,
  input wire logic rtc_evt_in,
  input wire logic sensor_evt_in,
  input wire logic ext_wake_in,
  input wire logic reset_pin_n_in,
  // clock sources
  input wire logic fast_osc_ready_in,
  input wire logic slow_xosc_present_in,
  input wire logic slow_crystal_osc_in,
  input wire logic slow_rc_osc_in,
  // pads
  input wire logic [NPAD-1:0] pad_in,
  output logic [NPAD-1:0] pad_out,
  output logic [NPAD-1:0] pad_oe_out,
  output logic lf_clk_pad_out,
  // power and clock control
  output pwr_seq_pkg::clk_ctrl_s clk_ctrl_out,
  output pwr_seq_pkg::pwr_ctrl_s pwr_ctrl_out,
  output logic cpu_rst_n_out,
  output logic cpu_resume_out,
  output logic irq_out
);
  localparam logic [16:0] IDLE_CNT = 17'(pwr_seq_pkg::IDLE_WAKE_CYC);
  localparam logic [16:0] STBY_CNT = 17'(STBY_WAKE_CYC);
  localparam logic [16:0] SHDN_CNT = 17'(SHDN_WAKE_CYC);
  localparam logic [9:0] BOD_LAST = 10'(pwr_seq_pkg::BOD_PERIOD_CYC - 1);
  localparam logic [9:0] BOD_ON = 10'(pwr_seq_pkg::BOD_ON_CYC);

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  pwr_seq_pkg::pwr_state_e state_r;
  pwr_seq_pkg::pwr_state_e state_nxt;
  logic [16:0] wake_cnt_r;
  logic warm_r;
  logic [1:0] ctrl_r;
  logic [2:0] cause_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [NPAD-1:0] wake_pin_r;
  logic [NPAD-1:0] pad_val_r;
  logic [NPAD-1:0] pad_en_r;
  logic [NPAD-1:0] latch_val_r;
  logic [NPAD-1:0] latch_oe_r;
  logic latch_hold_r;
  logic [NPAD-1:0] pad_prev_r;
  logic [NPAD-1:0] pad_edge;
  logic [9:0] bod_cnt_r;
  logic lf_clk_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic wr_ctrl;
  logic wr_mode;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic wr_wake_pin;
  logic wr_pad_out;
  logic wr_pad_oe;
  logic pin_rst;
  logic pad_wake;
  logic shdn_wake;
  logic cold_evt;
  logic wake_done;
  logic wake_tmo;
  logic entering_latch;
  logic pad_rel;

  assign wr_ctrl = wr_en_in && (addr_in == pwr_seq_pkg::ADDR_CTRL);
  assign wr_mode = wr_en_in && (addr_in == pwr_seq_pkg::ADDR_MODE);
  assign wr_irq_stat = wr_en_in && (addr_in == pwr_seq_pkg::ADDR_IRQ_STAT);
  assign wr_irq_mask = wr_en_in && (addr_in == pwr_seq_pkg::ADDR_IRQ_MASK);
  assign wr_wake_pin = wr_en_in && (addr_in == pwr_seq_pkg::ADDR_WAKE_PIN);
  assign wr_pad_out = wr_en_in && (addr_in == pwr_seq_pkg::ADDR_PAD_OUT);
  assign wr_pad_oe = wr_en_in && (addr_in == pwr_seq_pkg::ADDR_PAD_OE);

  // ----------------------------------------
  // pad edge detection
  // ----------------------------------------
  // one process owns the whole history vector
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_prev_r <= '0;
    end else begin
      pad_prev_r <= pad_in;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPAD; gi++) begin : g_pad
      assign pad_edge[gi] = pad_in[gi] ^ pad_prev_r[gi];
    end
  endgenerate

  assign pin_rst = !reset_pin_n_in;
  assign pad_wake = |(pad_edge & wake_pin_r);
  assign shdn_wake = (state_r == pwr_seq_pkg::ST_SHDN) && pad_wake;
  assign cold_evt = pin_rst || shdn_wake;
  assign wake_done = (state_r == pwr_seq_pkg::ST_WAKE) && fast_osc_ready_in;
  assign wake_tmo = (state_r == pwr_seq_pkg::ST_WAKE) && (wake_cnt_r == 17'h00001)
                    && !fast_osc_ready_in;
  assign entering_latch = (state_nxt == pwr_seq_pkg::ST_STBY
                           || state_nxt == pwr_seq_pkg::ST_SHDN
                           || state_nxt == pwr_seq_pkg::ST_HELD)
                          && (state_r == pwr_seq_pkg::ST_ACTIVE);
  // a pad write only frees the latch while running, never in a low-power mode
  assign pad_rel = wr_pad_out && (state_r == pwr_seq_pkg::ST_ACTIVE);

  // ----------------------------------------
  // mode state machine
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pwr_seq_pkg::ST_ACTIVE: begin
        if (wr_mode) begin
          case (wr_data_in[2:0])
            pwr_seq_pkg::MODE_IDLE: state_nxt = pwr_seq_pkg::ST_IDLE;
            pwr_seq_pkg::MODE_STBY: state_nxt = pwr_seq_pkg::ST_STBY;
            pwr_seq_pkg::MODE_SHDN: state_nxt = pwr_seq_pkg::ST_SHDN;
            pwr_seq_pkg::MODE_HELD: state_nxt = pwr_seq_pkg::ST_HELD;
            default: state_nxt = pwr_seq_pkg::ST_ACTIVE;
          endcase
        end
      end
      pwr_seq_pkg::ST_IDLE: begin
        if (irq_in || pad_wake || rtc_evt_in || sensor_evt_in) begin
          state_nxt = pwr_seq_pkg::ST_WAKE;
        end
      end
      pwr_seq_pkg::ST_STBY: begin
        if (ext_wake_in || rtc_evt_in || sensor_evt_in || pad_wake) begin
          state_nxt = pwr_seq_pkg::ST_WAKE;
        end
      end
      pwr_seq_pkg::ST_WAKE: begin
        if (fast_osc_ready_in) begin
          state_nxt = pwr_seq_pkg::ST_ACTIVE;
        end
      end
      default: state_nxt = state_r;
    endcase
    if (cold_evt) begin
      state_nxt = pwr_seq_pkg::ST_WAKE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= pwr_seq_pkg::ST_WAKE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // wake deadline counter, loaded by the mode being left, or with the shutdown deadline on a cold event
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_cnt_r <= 17'h00000;
    end else if (state_nxt == pwr_seq_pkg::ST_WAKE && state_r != pwr_seq_pkg::ST_WAKE) begin
      if (state_r == pwr_seq_pkg::ST_IDLE && !cold_evt) begin
        wake_cnt_r <= IDLE_CNT;
      end else if (state_r == pwr_seq_pkg::ST_STBY && !cold_evt) begin
        wake_cnt_r <= STBY_CNT;
      end else begin
        wake_cnt_r <= SHDN_CNT;
      end
    end else if (wake_cnt_r != 17'h00000) begin
      wake_cnt_r <= wake_cnt_r - 17'h00001;
    end
  end

  // warm wake resumes in place, cold wake boots
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      warm_r <= 1'b0;
    end else if (cold_evt) begin
      warm_r <= 1'b0;
    end else if (state_r == pwr_seq_pkg::ST_IDLE || state_r == pwr_seq_pkg::ST_STBY) begin
      warm_r <= 1'b1;
    end else if (state_r == pwr_seq_pkg::ST_ACTIVE) begin
      warm_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // reset cause
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cause_r <= pwr_seq_pkg::CAUSE_POR;
    end else if (pin_rst) begin
      cause_r <= pwr_seq_pkg::CAUSE_PIN;
    end else if (shdn_wake) begin
      cause_r <= pwr_seq_pkg::CAUSE_WAKEPIN;
    end
  end

  // ----------------------------------------
  // software registers, lost on a cold event
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= pwr_seq_pkg::CTRL_RST;
      irq_mask_r <= pwr_seq_pkg::IRQ_RST;
    end else if (cold_evt) begin
      ctrl_r <= pwr_seq_pkg::CTRL_RST;
      irq_mask_r <= pwr_seq_pkg::IRQ_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wr_data_in[1:0];
      end
      if (wr_irq_mask) begin
        irq_mask_r <= wr_data_in[2:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_pin_r <= '0;
      pad_val_r <= '0;
      pad_en_r <= '0;
    end else if (cold_evt) begin
      wake_pin_r <= '0;
      pad_val_r <= '0;
      pad_en_r <= '0;
    end else begin
      if (wr_wake_pin) begin
        wake_pin_r <= wr_data_in[NPAD-1:0];
      end
      if (wr_pad_out) begin
        pad_val_r <= wr_data_in[NPAD-1:0];
      end
      if (wr_pad_oe) begin
        pad_en_r <= wr_data_in[NPAD-1:0];
      end
    end
  end

  // ----------------------------------------
  // interrupt status, set wins over clear
  // ----------------------------------------
  logic [2:0] irq_set;
  assign irq_set = {(state_r == pwr_seq_pkg::ST_ACTIVE) && |pad_edge, wake_tmo, wake_done};

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= pwr_seq_pkg::IRQ_RST;
    end else if (cold_evt) begin
      irq_stat_r <= pwr_seq_pkg::IRQ_RST;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_irq_stat ? wr_data_in[2:0] : 3'h0)) | irq_set;
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------
  // pad latch
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_val_r <= '0;
      latch_oe_r <= '0;
    end else if (entering_latch) begin
      latch_val_r <= pad_val_r;
      latch_oe_r <= pad_en_r;
    end
  end

  // hold after cold wake until software rewrites the pad values
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_hold_r <= 1'b0;
    end else if (entering_latch) begin
      latch_hold_r <= 1'b1;
    end else if (pad_rel) begin
      latch_hold_r <= 1'b0;
    end else if (wake_done && warm_r) begin
      latch_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_out <= '0;
      pad_oe_out <= '0;
    end else if (latch_hold_r && !pad_rel) begin
      pad_out <= latch_val_r;
      pad_oe_out <= latch_oe_r;
    end else begin
      pad_out <= wr_pad_out ? wr_data_in[NPAD-1:0] : pad_val_r;
      pad_oe_out <= pad_en_r;
    end
  end

  // ----------------------------------------
  // low-speed clock select and pad route
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lf_clk_r <= 1'b0;
    end else if (ctrl_r[pwr_seq_pkg::CTRL_LF_XTAL_BIT] && slow_xosc_present_in) begin
      lf_clk_r <= slow_crystal_osc_in;
    end else begin
      lf_clk_r <= slow_rc_osc_in;
    end
  end

  assign lf_clk_pad_out = lf_clk_r && ctrl_r[pwr_seq_pkg::CTRL_LF_PAD_BIT];

  // ----------------------------------------
  // brown-out duty cycle divider
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bod_cnt_r <= 10'h000;
    end else if (bod_cnt_r == BOD_LAST) begin
      bod_cnt_r <= 10'h000;
    end else begin
      bod_cnt_r <= bod_cnt_r + 10'h001;
    end
  end

  // ----------------------------------------
  // clock and power enables
  // ----------------------------------------
  logic run;
  logic live;
  assign run = (state_r == pwr_seq_pkg::ST_ACTIVE);
  assign live = run || (state_r == pwr_seq_pkg::ST_IDLE) || (state_r == pwr_seq_pkg::ST_WAKE);

  always_comb begin
    clk_ctrl_out.cpu_en = run;
    clk_ctrl_out.mem_en = run;
    clk_ctrl_out.periph_en = live;
    clk_ctrl_out.fast_osc_en = live;
    clk_ctrl_out.fast_dbl_en = live;
    pwr_ctrl_out.aon_en = live || (state_r == pwr_seq_pkg::ST_STBY);
    pwr_ctrl_out.sensor_en = live || (state_r == pwr_seq_pkg::ST_STBY);
    pwr_ctrl_out.bod_en = live
                          || ((state_r == pwr_seq_pkg::ST_STBY) && (bod_cnt_r < BOD_ON));
    pwr_ctrl_out.por_en = (state_r != pwr_seq_pkg::ST_HELD);
  end

  assign cpu_rst_n_out = !(state_r == pwr_seq_pkg::ST_WAKE && !warm_r);
  assign cpu_resume_out = warm_r;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 32'h00000000;
    end else if (!rd_en_in) begin
      rd_data_out <= 32'h00000000;
    end else if (addr_in == pwr_seq_pkg::ADDR_CTRL) begin
      rd_data_out <= {30'h0, ctrl_r};
    end else if (addr_in == pwr_seq_pkg::ADDR_MODE) begin
      rd_data_out <= {28'h0, fast_osc_ready_in, state_r};
    end else if (addr_in == pwr_seq_pkg::ADDR_CAUSE) begin
      rd_data_out <= {29'h0, cause_r};
    end else if (addr_in == pwr_seq_pkg::ADDR_IRQ_STAT) begin
      rd_data_out <= {29'h0, irq_stat_r};
    end else if (addr_in == pwr_seq_pkg::ADDR_IRQ_MASK) begin
      rd_data_out <= {29'h0, irq_mask_r};
    end else if (addr_in == pwr_seq_pkg::ADDR_WAKE_PIN) begin
      rd_data_out <= 32'(wake_pin_r);
    end else if (addr_in == pwr_seq_pkg::ADDR_PAD_OUT) begin
      rd_data_out <= 32'(pad_val_r);
    end else if (addr_in == pwr_seq_pkg::ADDR_PAD_OE) begin
      rd_data_out <= 32'(pad_en_r);
    end else if (addr_in == pwr_seq_pkg::ADDR_PAD_IN) begin
      rd_data_out <= 32'(pad_in);
    end else begin
      rd_data_out <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_idle_gate;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r == pwr_seq_pkg::ST_IDLE |-> !clk_ctrl_out.cpu_en && clk_ctrl_out.periph_en;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("idle clock gating wrong");

  property p_idle_irq;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r == pwr_seq_pkg::ST_IDLE && irq_in |=> state_r == pwr_seq_pkg::ST_WAKE;
  endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("idle ignored interrupt");

  property p_wake_load;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r == pwr_seq_pkg::ST_IDLE && !cold_evt && state_nxt == pwr_seq_pkg::ST_WAKE
    |=> wake_cnt_r == IDLE_CNT;
  endproperty
  a_wake_load: assert property (p_wake_load) else $error("idle wake deadline wrong");

  property p_stby_irq;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r == pwr_seq_pkg::ST_STBY && irq_in && !ext_wake_in && !rtc_evt_in
    && !sensor_evt_in && !pad_wake && !pin_rst |=> state_r == pwr_seq_pkg::ST_STBY;
  endproperty
  a_stby_irq: assert property (p_stby_irq) else $error("standby left on interrupt");

  property p_stby_pads;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r == pwr_seq_pkg::ST_STBY && $past(state_r) == pwr_seq_pkg::ST_STBY
    |-> $stable(pad_out);
  endproperty
  a_stby_pads: assert property (p_stby_pads) else $error("pad moved in standby");

  property p_shdn_off;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r == pwr_seq_pkg::ST_SHDN |-> !pwr_ctrl_out.aon_en && !pwr_ctrl_out.sensor_en
    && !pwr_ctrl_out.bod_en && pwr_ctrl_out.por_en;
  endproperty
  a_shdn_off: assert property (p_shdn_off) else $error("shutdown power wrong");

  property p_shdn_cause;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    shdn_wake && !pin_rst |=> cause_r == pwr_seq_pkg::CAUSE_WAKEPIN
    && state_r == pwr_seq_pkg::ST_WAKE && !warm_r;
  endproperty
  a_shdn_cause: assert property (p_shdn_cause) else $error("wake pin not a reset");

  property p_held_pad;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r == pwr_seq_pkg::ST_HELD && !pin_rst |=> state_r == pwr_seq_pkg::ST_HELD;
  endproperty
  a_held_pad: assert property (p_held_pad) else $error("held left without reset pin");

  property p_pin_wake;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    pin_rst |=> state_r == pwr_seq_pkg::ST_WAKE && cause_r == pwr_seq_pkg::CAUSE_PIN;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("reset pin not honoured");

  property p_cpu_hold;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !fast_osc_ready_in && state_r == pwr_seq_pkg::ST_WAKE
    |=> !clk_ctrl_out.cpu_en;
  endproperty
  a_cpu_hold: assert property (p_cpu_hold) else $error("cpu ran before fast clock");
endmodule : power_mode_sequencer

// ===== verif/osc_model.sv
// clock source model: fast oscillator start-up and slow oscillators
`timescale 1ns/10ps
module osc_model #(
  parameter int START_CYC = 20
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // oscillators
  input wire logic fast_en_in,
  output logic fast_ready_out,
  output logic slow_xtal_out,
  output logic slow_rc_out
);
  int cnt;
  logic [2:0] div_r;
  // fast crystal settles only after a start-up delay
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
      fast_ready_out <= 1'b0;
    end else if (!fast_en_in) begin
      cnt <= 0;
      fast_ready_out <= 1'b0;
    end else if (cnt < START_CYC) begin
      cnt <= cnt + 1;
    end else begin
      fast_ready_out <= 1'b1;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  assign slow_rc_out = div_r[1];
  assign slow_xtal_out = div_r[2];
endmodule : osc_model

// ===== verif/power_mode_sequencer_tb.sv
// self-checking bench of the power-mode sequencer
`timescale 1ns/10ps
module power_mode_sequencer_tb;
  logic clk, rst_n, we, re, irq, rtc, sens, ext, rpin_n, rdy, sx, sr, lf, cpu_rst_n, resume, irq_o;
  logic xp;
  logic [7:0] addr, pin, pout, poe;
  logic [31:0] wdat, rd;
  pwr_seq_pkg::clk_ctrl_s cc;
  pwr_seq_pkg::pwr_ctrl_s pc;
  int num_errors, n_tests, cyc;
  power_mode_sequencer #(.STBY_WAKE_CYC(50), .SHDN_WAKE_CYC(200)) uut (
    .sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wr_data_in(wdat), .wr_en_in(we),
    .rd_en_in(re), .rd_data_out(rd), .irq_in(irq), .rtc_evt_in(rtc), .sensor_evt_in(sens),
    .ext_wake_in(ext), .reset_pin_n_in(rpin_n), .fast_osc_ready_in(rdy),
    .slow_xosc_present_in(xp), .slow_crystal_osc_in(sx), .slow_rc_osc_in(sr),
    .pad_in(pin), .pad_out(pout), .pad_oe_out(poe), .lf_clk_pad_out(lf), .clk_ctrl_out(cc),
    .pwr_ctrl_out(pc), .cpu_rst_n_out(cpu_rst_n), .cpu_resume_out(resume), .irq_out(irq_o));
  osc_model osc (.clk_in(clk), .rst_n_in(rst_n), .fast_en_in(cc.fast_osc_en),
    .fast_ready_out(rdy), .slow_xtal_out(sx), .slow_rc_out(sr));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(what, exp, rd);
  endtask : rdc
  // waits for the processor clock, bounded by the wake deadline
  task automatic wait_act(input int lim);
    int i;
    i = 0;
    while (cc.cpu_en !== 1'b1 && i < lim) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("cpu_en", 32'h1, 32'(cc.cpu_en));
  endtask : wait_act
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    wait_act(3000);
    rdc("cause", pwr_seq_pkg::ADDR_CAUSE, 32'(pwr_seq_pkg::CAUSE_POR));
    rdc("unmapped", 8'hFC, 32'h0);
    chk("bod", 32'h1, 32'(pc.bod_en));
    chk("fast dbl", 32'h1, 32'(cc.fast_dbl_en));
    $display("reset test done");
  endtask : t_reset
  task automatic t_idle();
    wr(pwr_seq_pkg::ADDR_IRQ_STAT, 32'h7);
    wr(pwr_seq_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(pwr_seq_pkg::ADDR_MODE, 32'(pwr_seq_pkg::MODE_IDLE));
    chk("idle gating", 32'h1, 32'({cc.cpu_en, cc.mem_en, cc.periph_en}));
    chk("irq quiet", 32'h0, 32'(irq_o));
    irq <= 1'b1;
    wait_act(1400);
    irq <= 1'b0;
    chk("irq out", 32'h1, 32'(irq_o));
    rdc("irq stat", pwr_seq_pkg::ADDR_IRQ_STAT, 32'h1);
    wr(pwr_seq_pkg::ADDR_IRQ_STAT, 32'h1);
    @(posedge clk);
    #1;
    chk("irq clear", 32'h0, 32'(irq_o));
    $display("idle test done");
  endtask : t_idle
  task automatic t_stby();
    wr(pwr_seq_pkg::ADDR_PAD_OE, 32'hFF);
    wr(pwr_seq_pkg::ADDR_PAD_OUT, 32'hA5);
    for (int k = 0; k < 3; k++) begin
      wr(pwr_seq_pkg::ADDR_MODE, 32'(pwr_seq_pkg::MODE_STBY));
      chk("fast osc", 32'h0, 32'(cc.fast_osc_en));
      chk("aon por", 32'h3, 32'({pc.aon_en, pc.por_en}));
      if (k == 0) begin
        wr(pwr_seq_pkg::ADDR_PAD_OUT, 32'h5A);
        repeat (3) @(posedge clk);
        #1;
        chk("pad latch", 32'hA5, 32'(pout));
        chk("pad oe", 32'hFF, 32'(poe));
      end
      irq <= 1'b1;
      repeat (5) @(posedge clk);
      irq <= 1'b0;
      #1;
      chk("no irq wake", 32'h0, 32'(cc.cpu_en));
      {ext, rtc, sens} <= 3'h1 << k;
      @(posedge clk);
      {ext, rtc, sens} <= 3'h0;
      repeat (2) @(posedge clk);
      #1;
      chk("warm", 32'h1, 32'(cpu_rst_n));
      wait_act(52);
      chk("resume", 32'h1, 32'(resume));
    end
    $display("standby test done");
  endtask : t_stby
  task automatic t_shdn();
    wr(pwr_seq_pkg::ADDR_WAKE_PIN, 32'h1);
    wr(pwr_seq_pkg::ADDR_PAD_OUT, 32'h3C);
    wr(pwr_seq_pkg::ADDR_MODE, 32'(pwr_seq_pkg::MODE_SHDN));
    chk("shdn pwr", 32'h1, 32'(pc));
    pin <= 8'h02;
    repeat (5) @(posedge clk);
    #1;
    chk("pad keep", 32'h3C, 32'(pout));
    chk("no wake", 32'h0, 32'(cc.cpu_en));
    pin <= 8'h03;
    repeat (3) @(posedge clk);
    #1;
    chk("cold", 32'h0, 32'(cpu_rst_n));
    wait_act(202);
    rdc("cause", pwr_seq_pkg::ADDR_CAUSE, 32'(pwr_seq_pkg::CAUSE_WAKEPIN));
    rdc("lost", pwr_seq_pkg::ADDR_WAKE_PIN, 32'h0);
    $display("shutdown test done");
  endtask : t_shdn
  task automatic t_held();
    wr(pwr_seq_pkg::ADDR_WAKE_PIN, 32'h1);
    wr(pwr_seq_pkg::ADDR_MODE, 32'(pwr_seq_pkg::MODE_HELD));
    pin <= 8'h02;
    repeat (10) @(posedge clk);
    #1;
    chk("held", 32'h0, 32'(cc.cpu_en));
    rpin_n <= 1'b0;
    repeat (2) @(posedge clk);
    rpin_n <= 1'b1;
    wait_act(202);
    rdc("cause", pwr_seq_pkg::ADDR_CAUSE, 32'(pwr_seq_pkg::CAUSE_PIN));
    $display("held test done");
  endtask : t_held
  task automatic t_clk();
    logic s;
    wr(pwr_seq_pkg::ADDR_IRQ_STAT, 32'h7);
    pin <= pin ^ 8'h80;
    repeat (2) @(posedge clk);
    rdc("pad edge", pwr_seq_pkg::ADDR_IRQ_STAT, 32'h4);
    rdc("mode", pwr_seq_pkg::ADDR_MODE, 32'h8);
    chk("lf off", 32'h0, 32'(lf));
    wr(pwr_seq_pkg::ADDR_CTRL, 32'h3);
    for (int k = 0; k < 2; k++) begin
      xp <= k[0];
      repeat (3) @(posedge clk);
      #1;
      s = lf;
      repeat (2 + 2 * k) @(posedge clk);
      #1;
      chk("lf clk", 32'(!s), 32'(lf));
    end
    $display("clock test done");
  endtask : t_clk
  // ----------------------------------------
  // run
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    cyc = 0;
    forever @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
        num_errors++;
        close_out();
      end
    end
  end
  initial begin
    {rst_n, we, re, irq, rtc, sens, ext} = 7'h0;
    rpin_n = 1'b1;
    xp = 1'b1;
    addr = 8'h00;
    wdat = 32'h0;
    pin = 8'h00;
    num_errors = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_idle();
    t_stby();
    t_shdn();
    t_held();
    t_clk();
    close_out();
  end
endmodule : power_mode_sequencer_tb
